// ===== core/tweep_consts.vh
/*
 * Constants for the two-wire serial memory slave: control byte layout,
 * address widths, page geometry, state codes and write-cycle timing.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef TWEEP_CONSTS_VH
`define TWEEP_CONSTS_VH

`define TWEEP_CLK_HZ        10000000
`define TWEEP_TWC_US        5000
`define TWEEP_TWC_CYCLES    ((`TWEEP_TWC_US / 1000) * (`TWEEP_CLK_HZ / 1000))
`define TWEEP_ADDR_W        11
`define TWEEP_MEM_DEPTH     2048
`define TWEEP_PAGE_BYTES    16
`define TWEEP_PAGE_W        4
`define TWEEP_CTRL_RW_BIT   0
`define TWEEP_CTRL_BLK_LSB  1
`define TWEEP_CTRL_BLK_MSB  3
`define TWEEP_CTRL_CODE_LSB 4
`define TWEEP_CTRL_CODE_MSB 7
`define TWEEP_BIT_LAST      3'h7
`define TWEEP_ADDR_ONE      11'h001
`define TWEEP_NIB_ONE       4'h1
`define TWEEP_ADDR_RESET    11'h000
`define TWEEP_BASE_RESET    7'h00
`define TWEEP_BYTE_MSB      7
`define TWEEP_LOW_W         8
`define TWEEP_TWC_W         23
`define TWEEP_TWC_ZERO      23'h00_0000
`define TWEEP_TWC_ONE       23'h00_0001
`define TWEEP_NIB_ZERO      4'h0
`define TWEEP_NIB_LAST      4'hf
`define TWEEP_BIT_ZERO      3'h0
`define TWEEP_BIT_ONE       3'h1
`define TWEEP_BYTE_ZERO     8'h00

`define TWEEP_ST_IDLE       3'h0
`define TWEEP_ST_CTRL       3'h1
`define TWEEP_ST_WADDR      3'h2
`define TWEEP_ST_WDATA      3'h3
`define TWEEP_ST_RDATA      3'h4
`define TWEEP_ST_RACK       3'h5

`endif

// ===== core/tweep_slave.v
/*
 * Two-wire serial memory slave: 2048 x 8 array, 16-byte page buffer,
 * self-timed write cycle, write-protect input, auto-incrementing pointer.
 * Assumes scl and sda come from pins (asynchronous to mclk, much slower)
 * and that an outer pad combines sda_out/sda_oe into an open-drain wire.
 */
`include "tweep_consts.vh"
`default_nettype none

// Operation
// - Device acknowledges every complete byte it receives while addressed.
// - Acknowledger holds SDA low through the whole acknowledge clock high.
// - Read ends on master not-acknowledge; device then releases SDA.
// - First byte after Start is the control byte, code field first.
// - Acknowledge control byte only on code match; R/W picks direction.
// - Three block-select bits form the top three word-address bits.
// - Final control bit one means read, zero means write.
// - Byte after write control byte loads low eight pointer bits.
// - Stop after write data starts programming; no acknowledges meanwhile.
// - Page write buffers up to 16 bytes, committed only after Stop.
// - Each write byte increments only low four pointer bits.
// - Beyond 16 bytes the page wraps, overwriting earlier positions.
// - Write-protect high inhibits programming of the whole array.
// - Master polls with write control bytes until acknowledge returns.
// - Pointer holds last address plus one for current-address reads.
// - Address write then repeated Start sets pointer, programs nothing.
// - Each master acknowledge sends next byte; pointer spans whole array.
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high.
// - Write-protect has no effect on reads.
module tweep_slave #(
    parameter integer TWC_CYCLES = `TWEEP_TWC_CYCLES
) (
    input  wire       mclk,
    input  wire       reset,
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       write_protect,
    output reg        write_busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_q;
    reg       sda_q;
    reg       wp_meta;
    reg       wp_q;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            wp_meta  <= 1'b0;
            wp_q     <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
            wp_meta  <= write_protect;
            wp_q     <= wp_meta;
        end
    end

    wire scl_s   = scl_sync[1];
    wire sda_s   = sda_sync[1];
    wire scl_ris = scl_s & ~scl_q;
    wire scl_fal = ~scl_s & scl_q;
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c  = scl_s & scl_q & ~sda_q & sda_s;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg  [7:0]                       mem [0:`TWEEP_MEM_DEPTH-1];
    wire [`TWEEP_PAGE_BYTES*8-1:0]   page_flat;
    wire [`TWEEP_PAGE_BYTES-1:0]     page_valid;

    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE  = `TWEEP_ST_IDLE;
    localparam [2:0] ST_CTRL  = `TWEEP_ST_CTRL;
    localparam [2:0] ST_WADDR = `TWEEP_ST_WADDR;
    localparam [2:0] ST_WDATA = `TWEEP_ST_WDATA;
    localparam [2:0] ST_RDATA = `TWEEP_ST_RDATA;
    localparam [2:0] ST_RACK  = `TWEEP_ST_RACK;

    // ------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------
    reg [2:0]                           state;
    reg [2:0]                           bit_cnt;
    reg                                 rx_full;
    reg [7:0]                           shift;
    reg                                 ack_phase;
    reg [`TWEEP_ADDR_W-1:0]             ptr;
    reg [`TWEEP_ADDR_W-1:`TWEEP_PAGE_W] page_base;
    reg                                 have_data;
    reg [7:0]                           tx_byte;
    reg                                 commit;
    reg [`TWEEP_PAGE_W-1:0]             commit_idx;
    reg [`TWEEP_TWC_W-1:0]              twc_cnt;

    // Device-type code; the value is arbitrary for this design
    localparam [3:0] CTRL_CODE = 4'h5;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Page-local increment: the upper pointer bits never move
    function [`TWEEP_ADDR_W-1:0] tweep_page_inc;
        input [`TWEEP_ADDR_W-1:0] a;
        begin
            tweep_page_inc = {a[`TWEEP_ADDR_W-1:`TWEEP_PAGE_W],
                              a[`TWEEP_PAGE_W-1:0] + `TWEEP_NIB_ONE};
        end
    endfunction

    // Low pointer bits select one page slot
    function tweep_slot_hit;
        input [`TWEEP_PAGE_W-1:0] low;
        input [`TWEEP_PAGE_W-1:0] slot;
        begin
            tweep_slot_hit = (low == slot);
        end
    endfunction

    // Device-type field of a received control byte
    function tweep_code_match;
        input [7:0] b;
        begin
            tweep_code_match =
                (b[`TWEEP_CTRL_CODE_MSB:`TWEEP_CTRL_CODE_LSB] == CTRL_CODE);
        end
    endfunction

    // ------------------------------------------------------------
    // Bit and byte events
    // ------------------------------------------------------------
    // Bits are counted on SCL rises only, so the fall that follows a
    // Start is never mistaken for the end of a bit
    wire                    bus_cond     = start_c | stop_c;
    wire [7:0]              rx_byte      = {shift[6:0], sda_s};
    wire [2:0]              bit_cnt_next = bit_cnt + `TWEEP_BIT_ONE;
    wire                    counting     = (state != ST_IDLE) && !ack_phase && !rx_full;
    wire                    byte_end     = scl_fal && !ack_phase && rx_full && !bus_cond;
    wire                    code_ok      = tweep_code_match(shift);
    wire                    can_ack      = code_ok && !write_busy && !commit;
    wire                    addr_load    = byte_end && (state == ST_WADDR);
    wire                    data_load    = byte_end && (state == ST_WDATA);
    wire                    commit_go    = stop_c && have_data && !wp_q;
    wire [7:0]              rd_byte      = mem[ptr];

    // ------------------------------------------------------------
    // Byte engine: sample on SCL rise, drive on SCL fall
    // ------------------------------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state     <= ST_IDLE;
            bit_cnt   <= `TWEEP_BIT_ZERO;
            rx_full   <= 1'b0;
            shift     <= `TWEEP_BYTE_ZERO;
            ack_phase <= 1'b0;
            ptr       <= `TWEEP_ADDR_RESET;
            page_base <= `TWEEP_BASE_RESET;
            have_data <= 1'b0;
            tx_byte   <= `TWEEP_BYTE_ZERO;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (bus_cond) begin
            // Any bus condition drops a partial byte and a pending ack
            state     <= start_c ? ST_CTRL : ST_IDLE;
            bit_cnt   <= `TWEEP_BIT_ZERO;
            rx_full   <= 1'b0;
            ack_phase <= 1'b0;
            sda_oe    <= 1'b0;
            // Repeated Start keeps the pointer but drops buffered data
            have_data <= 1'b0;
        end else begin
            if (scl_ris && counting) begin
                shift   <= rx_byte;
                bit_cnt <= bit_cnt_next;
                if (bit_cnt == `TWEEP_BIT_LAST)
                    rx_full <= 1'b1;
            end
            if (scl_ris && ack_phase && state == ST_RACK) begin
                // Master not-acknowledge ends the read
                if (sda_s)
                    state <= ST_IDLE;
                else
                    state <= ST_RDATA;
            end
            if (scl_fal) begin
                if (ack_phase) begin
                    // Ack has stood through the whole high phase
                    ack_phase <= 1'b0;
                    if (state == ST_RDATA) begin
                        tx_byte <= rd_byte;
                        sda_oe  <= ~rd_byte[`TWEEP_BYTE_MSB];
                    end else begin
                        sda_oe  <= 1'b0;
                    end
                end else if (rx_full) begin
                    rx_full <= 1'b0;
                    case (state)
                        ST_CTRL: begin
                            if (can_ack) begin
                                sda_oe    <= 1'b1;
                                ack_phase <= 1'b1;
                                ptr[`TWEEP_ADDR_W-1:`TWEEP_LOW_W] <=
                                    shift[`TWEEP_CTRL_BLK_MSB:`TWEEP_CTRL_BLK_LSB];
                                if (shift[`TWEEP_CTRL_RW_BIT])
                                    state <= ST_RDATA;
                                else
                                    state <= ST_WADDR;
                            end else begin
                                // Wrong code or busy: stay off the bus
                                state <= ST_IDLE;
                            end
                        end
                        ST_WADDR: begin
                            sda_oe    <= 1'b1;
                            ack_phase <= 1'b1;
                            ptr[`TWEEP_LOW_W-1:0] <= shift;
                            page_base <= {ptr[`TWEEP_ADDR_W-1:`TWEEP_LOW_W],
                                          shift[`TWEEP_BYTE_MSB:`TWEEP_PAGE_W]};
                            state     <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            sda_oe    <= 1'b1;
                            ack_phase <= 1'b1;
                            have_data <= 1'b1;
                            ptr       <= tweep_page_inc(ptr);
                        end
                        ST_RDATA: begin
                            // Release for the master's acknowledge bit
                            sda_oe    <= 1'b0;
                            ack_phase <= 1'b1;
                            ptr       <= ptr + `TWEEP_ADDR_ONE;
                            state     <= ST_RACK;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end else if (state == ST_RDATA) begin
                    // Next data bit, most significant first
                    sda_oe <= ~tx_byte[`TWEEP_BIT_LAST - bit_cnt];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Page buffer: one slot per byte of the page
    // ------------------------------------------------------------
    // A new word address empties the buffer; later bytes that land on
    // an already filled slot simply replace it
    genvar gi;
    generate
        for (gi = 0; gi < `TWEEP_PAGE_BYTES; gi = gi + 1) begin : g_slot
            localparam [`TWEEP_PAGE_W-1:0] SLOT = gi;
            reg [7:0] slot_data;
            reg       slot_valid;

            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    slot_data  <= `TWEEP_BYTE_ZERO;
                    slot_valid <= 1'b0;
                end else if (addr_load) begin
                    slot_valid <= 1'b0;
                end else if (data_load && tweep_slot_hit(ptr[`TWEEP_PAGE_W-1:0], SLOT)) begin
                    slot_data  <= shift;
                    slot_valid <= 1'b1;
                end
            end

            assign page_flat[gi*8 +: 8] = slot_data;
            assign page_valid[gi]       = slot_valid;
        end
    endgenerate

    // ------------------------------------------------------------
    // Self-timed write cycle
    // ------------------------------------------------------------
    // The copy takes one clock per slot; control bytes are refused until it
    // ends, since a new address would empty the buffer mid-copy
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            commit     <= 1'b0;
            commit_idx <= `TWEEP_NIB_ZERO;
            write_busy <= 1'b0;
            twc_cnt    <= `TWEEP_TWC_ZERO;
        end else if (commit_go) begin
            commit     <= 1'b1;
            commit_idx <= `TWEEP_NIB_ZERO;
            write_busy <= 1'b1;
            twc_cnt    <= TWC_CYCLES[`TWEEP_TWC_W-1:0] - `TWEEP_TWC_ONE;
        end else begin
            if (commit) begin
                commit_idx <= commit_idx + `TWEEP_NIB_ONE;
                if (commit_idx == `TWEEP_NIB_LAST)
                    commit <= 1'b0;
            end
            if (write_busy) begin
                if (twc_cnt == `TWEEP_TWC_ZERO)
                    write_busy <= 1'b0;
                else
                    twc_cnt <= twc_cnt - `TWEEP_TWC_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Array write port
    // ------------------------------------------------------------
    // Only slots filled since the address byte are copied
    always @(posedge mclk) begin
        if (commit && page_valid[commit_idx])
            mem[{page_base, commit_idx}] <= page_flat[commit_idx*8 +: 8];
    end

endmodule // tweep_slave

`default_nettype wire

// ===== verification/tweep_master.sv
/*
 * Bus master model for the two-wire memory slave: makes scl, pulls sda low.
 * Assumes the bench resolves sda as an open-drain wire with a pull-up.
 */
`default_nettype none
module tweep_master (
    input  wire logic mclk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ----------------------------------------
    // Bus phases: 800 ns per bit, sda moves mid-low
    // ----------------------------------------
    task automatic clk(input logic d, output logic s);
        @(posedge mclk) scl <= 1'b0;
        repeat (2) @(posedge mclk);
        sda_low <= ~d;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (3) @(posedge mclk);
        s = sda;
    endtask
    task automatic start();
        logic s;
        clk(1'b1, s);
        @(posedge mclk) sda_low <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    task automatic stop();
        logic s;
        clk(1'b0, s);
        @(posedge mclk) sda_low <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk(b[i], s);
        clk(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk(1'b1, s);
            d[i] = s;
        end
        clk(~more, s);
    endtask
endmodule // tweep_master
`default_nettype wire

// ===== verification/tweep_slave_sva.sv
/*
 * Pin-level assertions for the two-wire memory slave.
 * Assumes scl and sda_in change only just after mclk rising edges.
 */
`default_nettype none
module tweep_slave_sva #(
    parameter int TWC_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic write_busy
);
    localparam int TWC_MAX = TWC_CYCLES + 4;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_od_low; sda_oe |-> !sda_out; endproperty
    a_od_low: assert property (p_od_low) else $error("sda driven high");
    property p_edge_low; $changed(sda_oe) |-> !scl; endproperty
    a_edge_low: assert property (p_edge_low) else $error("sda moved in scl high");
    property p_ack_hold; $rose(sda_oe) |=> sda_oe [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack cut short");
    property p_busy_quiet; write_busy |-> !sda_oe; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_len; $rose(write_busy) |-> ##[1:TWC_MAX] !write_busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
    property p_busy_min; $rose(write_busy) |=> write_busy [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
    property p_wp_busy; $rose(write_busy) |-> !write_protect; endproperty
    a_wp_busy: assert property (p_wp_busy) else $error("protected write ran");
    property p_busy_idle; $rose(write_busy) |-> sda_in && !sda_oe; endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("cycle not after stop");
    c_busy: cover property ($rose(write_busy));
    c_ack_wp: cover property ($rose(sda_oe) && write_protect);
    c_end: cover property ($fell(write_busy));
endmodule // tweep_slave_sva
bind tweep_slave tweep_slave_sva #(.TWC_CYCLES(TWC_CYCLES)) u_sva (.mclk(mclk),
    .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .write_busy(write_busy));
`default_nettype wire

// ===== verification/two_wire_eeprom_slave_test.sv
/*
 * Self-checking bench for the two-wire memory slave.
 * Assumes the slave's device-type code is 4'h5 and its write cycle is shortened.
 */
`default_nettype none
module two_wire_eeprom_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       write_protect = 1'b0;
    wire logic  scl, sda_low, sda_out, sda_oe, write_busy;
    wire logic  sda = !(sda_oe || sda_low);
    int         err_total = 0;
    int         total_checks = 0;
    logic       a;
    logic [7:0] d;
    logic [8:0] rows [5] = '{9'h150, 9'h030, 9'h15e, 9'h0f0, 9'h152};
    always #50 mclk = ~mclk;
    tweep_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
    tweep_slave #(.TWC_CYCLES(400)) dut (.mclk(mclk), .reset(reset), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .write_protect(write_protect), .write_busy(write_busy));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] ad);
        m.start();
        m.wbyte(c, a);
        chk(a, 1);
        m.wbyte(ad, a);
        chk(a, 1);
    endtask
    task automatic rr(input logic [7:0] c, input logic [7:0] ad);
        wr(c, ad);
        m.start();
        m.wbyte(c | 8'h01, a);
        chk(a, 1);
    endtask
    task automatic wait_idle();
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 600 && write_busy !== 1'b0; i++) @(posedge mclk);
        chk(write_busy, 0);
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #4000000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(sda_oe, 0);
        chk(write_busy, 0);
        $display("reset test done");
        for (int r = 0; r < 5; r++) begin
            m.start();
            m.wbyte(rows[r][7:0], a);
            m.stop();
            chk(a, rows[r][8]);
            chk(write_busy, 0);
        end
        $display("control byte table done");
        // Partial byte then stop must not upset the next command
        m.start();
        for (int i = 0; i < 4; i++) m.clk(1'b1, a);
        m.stop();
        wr(8'h5a, 8'h23);
        m.wbyte(8'hc3, a);
        chk(a, 1);
        m.stop();
        repeat (6) @(posedge mclk);
        chk(write_busy, 1);
        m.start();
        m.wbyte(8'h5a, a);
        m.stop();
        chk(a, 0);
        wait_idle();
        m.start();
        m.wbyte(8'h5a, a);
        m.stop();
        chk(a, 1);
        rr(8'h5a, 8'h23);
        m.rbyte(1'b0, d);
        m.stop();
        chk(d, 8'hc3);
        $display("byte write and random read done");
        wr(8'h50, 8'h0e);
        for (int i = 0; i < 18; i++) begin
            m.wbyte(8'h10 + 8'(i), a);
            chk(a, 1);
        end
        m.stop();
        wait_idle();
        rr(8'h50, 8'h00);
        for (int p = 0; p < 15; p++) begin
            m.rbyte(p < 14, d);
            chk(d, 8'h10 + 8'((p + 2) % 16) + (p >= 14 ? 8'h10 : 8'h00));
        end
        m.stop();
        m.start();
        m.wbyte(8'h51, a);
        m.rbyte(1'b0, d);
        m.stop();
        chk(d, 8'h21);
        $display("page wrap and sequential read done");
        @(posedge mclk) write_protect <= 1'b1;
        wr(8'h5a, 8'h23);
        m.wbyte(8'h3c, a);
        m.stop();
        repeat (6) @(posedge mclk);
        chk(write_busy, 0);
        rr(8'h5a, 8'h23);
        m.rbyte(1'b0, d);
        m.stop();
        chk(d, 8'hc3);
        $display("write protect done");
        close_out();
    end
endmodule // two_wire_eeprom_slave_test
`default_nettype wire
